// file: rmf_pkg.sv
// How it works
// - Bit 7 and bits 31:16 read zero.
// - Index field holds first pending record index.
// - Index field meaningful only while summary set.
// - Set time-out flag on completion time-out.
// - Set completion error flag on bad completion.
// - No endpoint cache: bits 6,5 reserved zero.
// - Set queue error flag; absent queue: zero.
// - Set advanced pending on first log record.
// - Set advanced overflow on log overflow.
// - No advanced logging: bits 3,2 reserved zero.
// - Summary bit is OR of record-pending bits.
// - Summary rising updates index, raises event.
// - Overflow flag set blocks new fault recording.
// - Event mask set blocks fault message; irq_o is not gated by it.
package rmf_pkg;
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;
	localparam int REC_N = 16;
	localparam int IDX_W = 8;
	localparam int FLG_W = 7;
	localparam logic [ADR_W-1:0] OFS_STATUS = 8'h34;
	localparam logic [ADR_W-1:0] OFS_EVCTL = 8'h38;
	localparam logic [ADR_W-1:0] OFS_IRQ_STAT = 8'h40;
	localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 8'h44;
	localparam int BIT_TIMEOUT = 6;
	localparam int BIT_CPL_ERR = 5;
	localparam int BIT_QUEUE = 4;
	localparam int BIT_ADV_PEND = 3;
	localparam int BIT_ADV_OVF = 2;
	localparam int BIT_SUMMARY = 1;
	localparam int BIT_PRI_OVF = 0;
	localparam int IDX_LSB = 8;
	localparam int BIT_EV_MASK = 31;
	localparam int BIT_EV_HELD = 30;
	localparam int LANE_LOW = 0;
	localparam int LANE_TOP = 3;
	localparam logic [FLG_W-1:0] STICKY_BITS = 7'h7d;
	localparam logic [FLG_W-1:0] FLAGS_RST = 7'h00;
	localparam logic [IDX_W-1:0] IDX_RST = 8'h00;
	localparam logic EV_MASK_RST = 1'b1;
	localparam logic [FLG_W-1:0] IRQ_MASK_RST = 7'h00;
	localparam logic [DAT_W-1:0] DAT_ZERO = 32'h0000_0000;
endpackage

// file: rmf_sticky_flag.sv
`timescale 1ns/1ns
module rmf_sticky_flag (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Control.
	input wire logic impl_i,
	input wire logic set_i,
	input wire logic clr_i,
	// State.
	output logic flag_o
);
	logic flag_reg;
	logic flag_next;

	// A set in the clearing cycle wins so the event is never lost.
	always_comb begin
		flag_next = impl_i & (set_i | (flag_reg & ~clr_i));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag_o = flag_reg;
endmodule // rmf_sticky_flag

// file: rmf_event_gen.sv
`timescale 1ns/1ns
module rmf_event_gen (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Event and mask.
	input wire logic event_i,
	input wire logic mask_i,
	// Message request.
	output logic send_o,
	output logic held_o
);
	logic send_reg;
	logic send_next;
	logic held_reg;
	logic held_next;

	// A masked event is held so that unmasking later still delivers it.
	always_comb begin
		send_next = 1'b0;
		held_next = held_reg;
		if (mask_i) begin
			held_next = held_reg | event_i;
		end else if (event_i || held_reg) begin
			send_next = 1'b1;
			held_next = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			send_reg <= 1'b0;
			held_reg <= 1'b0;
		end else begin
			send_reg <= send_next;
			held_reg <= held_next;
		end
	end

	assign send_o = send_reg;
	assign held_o = held_reg;
endmodule // rmf_event_gen

// file: rmf_fault_status.sv
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ns
module rmf_fault_status
	import rmf_pkg::*;
#(
	parameter bit HAS_EP_CACHE = 1'b1,
	parameter bit HAS_QUEUE = 1'b1,
	parameter bit HAS_ADV_LOG = 1'b1
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [SEL_W-1:0] wb_sel_i,
	input wire logic [DAT_W-1:0] wb_dat_i,
	output logic [DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Hardware fault events.
	input wire logic inval_timeout_i,
	input wire logic inval_cpl_error_i,
	input wire logic queue_error_i,
	input wire logic adv_first_record_i,
	input wire logic adv_overflow_i,
	input wire logic record_overflow_i,
	input wire logic [REC_N-1:0] record_pending_i,
	// Fault recording control and event outputs.
	output logic record_hold_o,
	output logic fault_msg_send_o,
	output logic irq_o
);
	function automatic logic [IDX_W-1:0] lowest_set(
		input logic [REC_N-1:0] vec
	);
		logic [IDX_W-1:0] idx;
		idx = IDX_RST;
		for (int i = REC_N - 1; i >= 0; i--) begin
			if (vec[i]) begin
				idx = IDX_W'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic [FLG_W-1:0] w1c_bits(
		input logic hit,
		input logic [SEL_W-1:0] sel,
		input logic [DAT_W-1:0] dat
	);
		logic [FLG_W-1:0] bits;
		bits = '0;
		if (hit && sel[LANE_LOW]) begin
			bits = dat[FLG_W-1:0];
		end
		return bits;
	endfunction

	// Bus state.
	logic ack_reg;
	logic ack_next;
	logic [DAT_W-1:0] rdata_reg;
	logic [DAT_W-1:0] rdata_next;
	logic req;
	logic wr_en;
	logic hit_status;
	logic hit_evctl;
	logic hit_irq_stat;
	logic hit_irq_mask;

	// Fault status state.
	logic [FLG_W-1:0] impl;
	logic [FLG_W-1:0] flag_set;
	logic [FLG_W-1:0] flag_clr;
	logic [FLG_W-1:0] flags;
	logic summary_reg;
	logic summary_next;
	logic [IDX_W-1:0] index_reg;
	logic [IDX_W-1:0] index_next;
	logic [FLG_W-1:0] rising;
	logic fault_event;

	// Event control and interrupt state.
	logic ev_mask_reg;
	logic ev_mask_next;
	logic ev_held;
	logic [FLG_W-1:0] irq_stat_reg;
	logic [FLG_W-1:0] irq_stat_next;
	logic [FLG_W-1:0] irq_mask_reg;
	logic [FLG_W-1:0] irq_mask_next;
	logic irq_reg;
	logic irq_next;

	// Address decode.
	always_comb begin
		hit_status = 1'b0;
		hit_evctl = 1'b0;
		hit_irq_stat = 1'b0;
		hit_irq_mask = 1'b0;
		if (wb_adr_i == OFS_STATUS) begin
			hit_status = 1'b1;
		end else if (wb_adr_i == OFS_EVCTL) begin
			hit_evctl = 1'b1;
		end else if (wb_adr_i == OFS_IRQ_STAT) begin
			hit_irq_stat = 1'b1;
		end else if (wb_adr_i == OFS_IRQ_MASK) begin
			hit_irq_mask = 1'b1;
		end
	end

	// Writes land on the acknowledged edge, the one the master samples.
	assign req = wb_cyc_i & wb_stb_i;
	assign wr_en = req & wb_we_i & ack_reg;

	// Read data is prepared in the request cycle and held with ack.
	always_comb begin
		ack_next = req & ~ack_reg;
		rdata_next = rdata_reg;
		if (req && !ack_reg) begin
			rdata_next = DAT_ZERO;
			if (hit_status) begin
				rdata_next[FLG_W-1:0] = flags & impl;
				rdata_next[BIT_SUMMARY] = summary_reg;
				rdata_next[IDX_LSB +: IDX_W] = index_reg;
			end else if (hit_evctl) begin
				rdata_next[BIT_EV_MASK] = ev_mask_reg;
				rdata_next[BIT_EV_HELD] = ev_held;
			end else if (hit_irq_stat) begin
				rdata_next[FLG_W-1:0] = irq_stat_reg;
			end else if (hit_irq_mask) begin
				rdata_next[FLG_W-1:0] = irq_mask_reg;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdata_reg <= DAT_ZERO;
		end else begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	// Missing features leave their flags permanently at zero.
	always_comb begin
		impl = STICKY_BITS;
		impl[BIT_TIMEOUT] = HAS_EP_CACHE;
		impl[BIT_CPL_ERR] = HAS_EP_CACHE;
		impl[BIT_QUEUE] = HAS_QUEUE;
		impl[BIT_ADV_PEND] = HAS_ADV_LOG;
		impl[BIT_ADV_OVF] = HAS_ADV_LOG;
	end

	always_comb begin
		flag_set = FLAGS_RST;
		flag_set[BIT_TIMEOUT] = inval_timeout_i;
		flag_set[BIT_CPL_ERR] = inval_cpl_error_i;
		flag_set[BIT_QUEUE] = queue_error_i;
		flag_set[BIT_ADV_PEND] = adv_first_record_i;
		flag_set[BIT_ADV_OVF] = adv_overflow_i;
		flag_set[BIT_PRI_OVF] = record_overflow_i;
		flag_clr = w1c_bits(wr_en & hit_status, wb_sel_i, wb_dat_i);
	end

	for (genvar g = 0; g < FLG_W; g++) begin : g_flag
		if (STICKY_BITS[g]) begin : g_sticky
			rmf_sticky_flag u_flag (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.impl_i(impl[g]),
				.set_i(flag_set[g]),
				.clr_i(flag_clr[g]),
				.flag_o(flags[g])
			);
		end else begin : g_none
			assign flags[g] = 1'b0;
		end
	end

	// The index is caught only on the rising summary; it stays stale after.
	always_comb begin
		summary_next = |record_pending_i;
		index_next = index_reg;
		if (summary_next && !summary_reg) begin
			index_next = lowest_set(record_pending_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			summary_reg <= 1'b0;
			index_reg <= IDX_RST;
		end else begin
			summary_reg <= summary_next;
			index_reg <= index_next;
		end
	end

	// Only a flag going from clear to set counts as a new fault event.
	always_comb begin
		rising = flag_set & impl & ~flags;
		rising[BIT_ADV_PEND] = flag_set[BIT_ADV_PEND] & impl[BIT_ADV_PEND]
			& ~flags[BIT_ADV_PEND];
		rising[BIT_SUMMARY] = summary_next & ~summary_reg;
		fault_event = |rising;
	end

	// Recording stalls while primary overflow stands.
	assign record_hold_o = flags[BIT_PRI_OVF];

	always_comb begin
		ev_mask_next = ev_mask_reg;
		if (wr_en && hit_evctl && wb_sel_i[LANE_TOP]) begin
			ev_mask_next = wb_dat_i[BIT_EV_MASK];
		end
	end

	rmf_event_gen u_event (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(fault_event),
		.mask_i(ev_mask_reg),
		.send_o(fault_msg_send_o),
		.held_o(ev_held)
	);

	// Interrupt status mirrors each new event; writes of one clear it.
	always_comb begin
		irq_stat_next = rising
			| (irq_stat_reg
			& ~w1c_bits(wr_en & hit_irq_stat, wb_sel_i, wb_dat_i));
		irq_mask_next = irq_mask_reg;
		if (wr_en && hit_irq_mask && wb_sel_i[LANE_LOW]) begin
			irq_mask_next = wb_dat_i[FLG_W-1:0];
		end
		irq_next = |(irq_stat_next & irq_mask_next);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ev_mask_reg <= EV_MASK_RST;
			irq_stat_reg <= FLAGS_RST;
			irq_mask_reg <= IRQ_MASK_RST;
			irq_reg <= 1'b0;
		end else begin
			ev_mask_reg <= ev_mask_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			irq_reg <= irq_next;
		end
	end

	assign irq_o = irq_reg;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_status_read;
		req && !wb_we_i && !ack_reg && hit_status;
	endsequence

	sequence s_clear_timeout;
		wr_en && hit_status && wb_sel_i[LANE_LOW]
			&& wb_dat_i[BIT_TIMEOUT] && !inval_timeout_i;
	endsequence

	sequence s_event_open;
		fault_event && !ev_mask_reg && !ev_held;
	endsequence

	AST_RSVD_ZERO: assert property (
		s_status_read |=> wb_ack_o && wb_dat_o[DAT_W-1:16] == '0
			&& !wb_dat_o[7])
		else $error("Reserved status bits read nonzero.");

	AST_INDEX_READ: assert property (
		s_status_read |=> wb_dat_o[IDX_LSB +: IDX_W] == $past(index_reg))
		else $error("Index field read differs from captured index.");

	AST_INDEX_STABLE: assert property (
		summary_reg && $stable(summary_reg) |-> $stable(index_reg))
		else $error("Index changed while summary stayed set.");

	AST_TIMEOUT_SET: assert property (
		inval_timeout_i && HAS_EP_CACHE |=> flags[BIT_TIMEOUT])
		else $error("Time-out flag not set.");

	AST_CPL_SET: assert property (
		inval_cpl_error_i && HAS_EP_CACHE |=> flags[BIT_CPL_ERR])
		else $error("Completion error flag not set.");

	AST_NO_EP_CACHE: assert property (
		!HAS_EP_CACHE |-> !flags[BIT_TIMEOUT] && !flags[BIT_CPL_ERR])
		else $error("Endpoint cache flags set without support.");

	AST_QUEUE_SET: assert property (
		queue_error_i |=> flags[BIT_QUEUE] == HAS_QUEUE)
		else $error("Queue error flag wrong.");

	AST_ADV_PEND_EVENT: assert property (
		adv_first_record_i && HAS_ADV_LOG && !flags[BIT_ADV_PEND]
			&& !ev_mask_reg |=> flags[BIT_ADV_PEND] ##0 fault_msg_send_o)
		else $error("Advanced pending did not raise an event.");

	AST_ADV_OVF_SET: assert property (
		adv_overflow_i |=> flags[BIT_ADV_OVF] == HAS_ADV_LOG)
		else $error("Advanced overflow flag wrong.");

	AST_NO_ADV_LOG: assert property (
		!HAS_ADV_LOG |-> !flags[BIT_ADV_PEND] && !flags[BIT_ADV_OVF])
		else $error("Advanced flags set without support.");

	AST_SUMMARY_OR: assert property (
		1'b1 |=> summary_reg == $past(|record_pending_i))
		else $error("Summary is not the OR of pending records.");

	AST_SUMMARY_RISE: assert property (
		$rose(summary_reg) |-> index_reg == $past(lowest_set(
			record_pending_i)) && irq_stat_reg[BIT_SUMMARY])
		else $error("Summary rise did not capture index and event.");

	AST_OVF_HOLD: assert property (
		record_overflow_i |=> record_hold_o)
		else $error("Recording not held after overflow.");

	AST_W1C_CLEAR: assert property (
		s_clear_timeout |=> !flags[BIT_TIMEOUT])
		else $error("Writing one did not clear the flag.");

	AST_SET_WINS: assert property (
		wr_en && hit_status && wb_dat_i[BIT_QUEUE] && queue_error_i
			&& HAS_QUEUE |=> flags[BIT_QUEUE])
		else $error("Set lost against a clear.");

	AST_ZERO_KEEPS: assert property (
		flags[BIT_PRI_OVF] && !(wr_en && hit_status
			&& wb_sel_i[LANE_LOW] && wb_dat_i[BIT_PRI_OVF])
			|=> flags[BIT_PRI_OVF])
		else $error("Flag cleared without a written one.");

	AST_MASK_BLOCKS: assert property (
		ev_mask_reg |=> !fault_msg_send_o)
		else $error("Message sent while masked.");

	AST_UNMASKED_SENDS: assert property (
		s_event_open |=> fault_msg_send_o)
		else $error("Unmasked event sent no message.");

	AST_ACK_PULSE: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge held longer than one cycle.");

	AST_IRQ_LEVEL: assert property (
		rising[BIT_QUEUE] && irq_mask_reg[BIT_QUEUE]
			&& !(wr_en && hit_irq_mask) |=> irq_o)
		else $error("Unmasked interrupt not raised.");
endmodule // rmf_fault_status

// file: rmf_fault_status_bench.sv
`timescale 1ns/1ns
module rmf_fault_status_bench
	import rmf_pkg::*;
;
	logic clk_i;
	logic rst_i;
	logic wb_cyc;
	logic wb_stb;
	logic wb_we;
	logic [ADR_W-1:0] wb_adr;
	logic [SEL_W-1:0] wb_sel;
	logic [DAT_W-1:0] wb_wdat;
	logic [DAT_W-1:0] wb_rdat;
	logic [DAT_W-1:0] rd_q;
	logic wb_ack;
	logic hold;
	logic send;
	logic irq;
	logic [5:0] ev;
	logic [REC_N-1:0] pend;
	int errors;
	int checks_done;
	int sends;
	int fb[6] = '{6, 5, 4, 3, 2, 0};

	rmf_fault_status dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb),
		.wb_we_i(wb_we),
		.wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel),
		.wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack),
		.inval_timeout_i(ev[0]),
		.inval_cpl_error_i(ev[1]),
		.queue_error_i(ev[2]),
		.adv_first_record_i(ev[3]),
		.adv_overflow_i(ev[4]),
		.record_overflow_i(ev[5]),
		.record_pending_i(pend),
		.record_hold_o(hold),
		.fault_msg_send_o(send),
		.irq_o(irq)
	);

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// Counting pulses catches both a missing message and a doubled one.
	always @(posedge clk_i) begin
		if (send === 1'b1) begin
			sends <= sends + 1;
		end
	end

	task give_verdict();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [DAT_W-1:0] exp,
		input logic [DAT_W-1:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// The request is held until ack is sampled high at a rising edge.
	task xfer(input logic w, input logic [ADR_W-1:0] a,
		input logic [DAT_W-1:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		wb_sel <= 4'hf;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 16);
		chk("ack", 32'h0000_0001, {31'h0, wb_ack});
		rd_q = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask

	task rdchk(input string nm, input logic [ADR_W-1:0] a,
		input logic [DAT_W-1:0] exp, input logic [DAT_W-1:0] msk);
		xfer(1'b0, a, DAT_ZERO);
		chk(nm, exp, rd_q & msk);
	endtask

	task pulse(input int k);
		@(posedge clk_i);
		ev[k] <= 1'b1;
		@(posedge clk_i);
		ev[k] <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		$display("[FAIL] watchdog expected done seen hang");
		give_verdict();
	end

	initial begin
		rst_i = 1'b1;
		{wb_cyc, wb_stb, wb_we} = 3'h0;
		wb_adr = 8'h00;
		wb_sel = 4'h0;
		wb_wdat = DAT_ZERO;
		ev = 6'h00;
		pend = 16'h0000;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk("status", OFS_STATUS, 32'h0, 32'hffff_ffff);
		rdchk("evctl", OFS_EVCTL, 32'h8000_0000, 32'hffff_ffff);
		rdchk("irq mask", OFS_IRQ_MASK, 32'h0, 32'hffff_ffff);
		rdchk("unmapped", 8'h10, 32'h0, 32'hffff_ffff);
		$display("test reset done");
		// Index bits are masked out: they are undefined while no fault pends.
		for (int k = 0; k < 6; k++) begin
			pulse(k);
			rdchk("flag", OFS_STATUS, 32'h1 << fb[k], 32'hffff_00ff);
			chk("hold", {31'h0, k == 5}, {31'h0, hold});
			xfer(1'b1, OFS_STATUS, 32'h0);
			rdchk("w0 flag", OFS_STATUS, 32'h1 << fb[k], 32'hffff_00ff);
			xfer(1'b1, OFS_STATUS, 32'hffff_ffff);
			rdchk("w1 flag", OFS_STATUS, 32'h0, 32'hffff_00ff);
			chk("hold off", 32'h0, {31'h0, hold});
		end
		chk("masked sends", 32'h0, sends);
		rdchk("held", OFS_EVCTL, 32'hc000_0000, 32'hffff_ffff);
		xfer(1'b1, OFS_EVCTL, 32'h0);
		repeat (3) @(posedge clk_i);
		chk("unmask sends", 32'h1, sends);
		$display("test flags done");
		pulse(0);
		chk("event sends", 32'h2, sends);
		pulse(0);
		chk("set again sends", 32'h2, sends);
		xfer(1'b1, OFS_STATUS, 32'hffff_ffff);
		$display("test events done");
		@(posedge clk_i);
		pend <= 16'h0050;
		repeat (3) @(posedge clk_i);
		rdchk("summary", OFS_STATUS, 32'h0402, 32'hffff_ffff);
		chk("summary send", 32'h3, sends);
		@(posedge clk_i);
		pend <= 16'h0052;
		rdchk("index kept", OFS_STATUS, 32'h0402, 32'hffff_ffff);
		@(posedge clk_i);
		pend <= 16'h0000;
		rdchk("no pend", OFS_STATUS, 32'h0, 32'hffff_00ff);
		@(posedge clk_i);
		pend <= 16'h8000;
		rdchk("index top", OFS_STATUS, 32'h0f02, 32'hffff_ffff);
		chk("second send", 32'h4, sends);
		@(posedge clk_i);
		pend <= 16'h0000;
		$display("test summary done");
		xfer(1'b1, OFS_IRQ_STAT, 32'h7f);
		xfer(1'b1, OFS_IRQ_MASK, 32'h10);
		chk("irq idle", 32'h0, {31'h0, irq});
		pulse(2);
		chk("irq on", 32'h1, {31'h0, irq});
		rdchk("irq stat", OFS_IRQ_STAT, 32'h10, 32'hffff_ffff);
		xfer(1'b1, OFS_IRQ_STAT, 32'h10);
		repeat (2) @(posedge clk_i);
		chk("irq clr", 32'h0, {31'h0, irq});
		xfer(1'b1, OFS_STATUS, 32'hffff_ffff);
		xfer(1'b1, OFS_IRQ_MASK, 32'h0);
		pulse(2);
		chk("irq masked", 32'h0, {31'h0, irq});
		rdchk("stat masked", OFS_IRQ_STAT, 32'h10, 32'hffff_ffff);
		xfer(1'b1, OFS_STATUS, 32'hffff_ffff);
		ev[2] <= 1'b1;
		xfer(1'b1, OFS_STATUS, 32'h10);
		ev[2] <= 1'b0;
		rdchk("set wins", OFS_STATUS, 32'h10, 32'hffff_00ff);
		$display("test interrupt done");
		give_verdict();
	end
endmodule // rmf_fault_status_bench
